// file: rsq_pkg.sv
// Shared constants, register map and state type for the repeated start sequencer
package rsq_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          BRG_W           = 8;
  // Register offsets
  localparam logic [7:0]  OFS_CTL_ONE     = 8'h00;
  localparam logic [7:0]  OFS_CTL_TWO     = 8'h01;
  localparam logic [7:0]  OFS_BAUD        = 8'h02;
  localparam logic [7:0]  OFS_STATUS      = 8'h03;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_CLR     = 8'h05;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h06;
  // Field positions of port_control_one
  localparam int          BIT_WRITE_COLLIDE_FLAG        = 7;
  localparam int          BIT_OVF         = 6;
  localparam int          BIT_PEN         = 5;
  localparam int          BIT_CPOL        = 4;
  localparam int          MODE_HI         = 3;
  // Field positions of port_control_two and port_status_reg
  localparam int          BIT_RESTART_ENABLE_BIT        = 1;
  localparam int          BIT_START       = 3;
  // Interrupt status bits
  localparam int          IRQ_EVENT       = 0;
  localparam int          IRQ_BCOL        = 1;
  localparam int          IRQ_W           = 2;
  // Reset values
  localparam logic [7:0]  RST_CTL_ONE     = 8'h00;
  localparam logic [7:0]  RST_BAUD        = 8'h04;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

  // Sequencer states
  typedef enum logic [2:0] {
    RSQ_IDLE,
    RSQ_SCL_LOW,
    RSQ_SDA_HIGH,
    RSQ_SCL_REL,
    RSQ_HOLD_HIGH,
    RSQ_SDA_LOW
  } rsq_state_t;
endpackage : rsq_pkg

// file: rsq_brg_if.sv
// Control link between the sequencer and its baud rate generator
`timescale 1ns/10ps
interface rsq_brg_if #(parameter int W = 8);
  logic         load;
  logic [W-1:0] reload;
  logic         expired;
  modport ctl (output load, output reload, input expired);
  modport brg (input load, input reload, output expired);
endinterface : rsq_brg_if

// file: rsq_brg.sv
// Baud rate generator: one period is reload plus two clock cycles
`timescale 1ns/10ps
module rsq_brg #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  rsq_brg_if.brg   link
);
  import rsq_pkg::*;

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         run_ff;
  logic         nxt_run;
  logic         exp_ff;
  logic         nxt_exp;

  // Count down after a load, pulse once on reaching zero
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (link.load) begin
      nxt_cnt = link.reload;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (cnt_ff == '0) begin
        nxt_run = 1'b0;
        nxt_exp = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  // Registers of the generator
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign link.expired = exp_ff;
endmodule : rsq_brg

// file: rsq_top.sv
// Repeated start sequencer with register port, collision check and interrupt
//
// Notes on behaviour
// - Restart enable set while idle starts sequence
// - First pull clock line low
// - Clock seen low: load generator, release data
// - Generator expired, data high: release clock
// - Clock seen high: reload, both high one period
// - Pull data low one period, then clock low
// - Finish: clear restart bit, no reload, data low
// - Start condition on lines sets start flag
// - Event flag only after final period expires
// - Restart request ignored while another event busy
// - Data low at clock rise is collision
// - Clock low before data pulled low is collision
// - Control one: 8 bits, flags, enable, mode
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module rsq_top (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [rsq_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rsq_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [rsq_pkg::DATA_W-1:0]      reg_rdata,
  input  wire logic                       other_event_busy,
  input  wire logic                       scl_i,
  output logic                            scl_o,
  output logic                            scl_oe,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  output logic                            irq
);
  import rsq_pkg::*;

  rsq_brg_if #(.W(BRG_W)) brg_link ();

  rsq_brg #(.W(BRG_W)) u_brg (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .link    (brg_link)
  );

  rsq_state_t        state_ff;
  rsq_state_t        nxt_state;
  logic [7:0]        ctl_one_ff;
  logic [7:0]        nxt_ctl_one;
  logic              restart_enable_bit_ff;
  logic              nxt_restart_enable_bit;
  logic [BRG_W-1:0]  baud_ff;
  logic [BRG_W-1:0]  nxt_baud;
  logic              start_ff;
  logic              nxt_start;
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  nxt_irq_stat;
  logic [IRQ_W-1:0]  irq_en_ff;
  logic [IRQ_W-1:0]  nxt_irq_en;
  logic [7:0]        rdata_ff;
  logic [7:0]        nxt_rdata;
  logic              irq_ff;
  logic              nxt_irq;
  logic              scl_oe_ff;
  logic              nxt_scl_oe;
  logic              sda_oe_ff;
  logic              nxt_sda_oe;
  logic              scl_q_ff;
  logic              sda_q_ff;
  logic              ev_done;
  logic              ev_bcol;
  logic              brg_load;

  // Write strobe decode helper
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction : wr_hit

  // Line went high between the last sample and this one
  function automatic logic rose_seen(input logic now_lvl, input logic was_lvl);
    rose_seen = now_lvl && !was_lvl;
  endfunction : rose_seen

  // Line went low between the last sample and this one
  function automatic logic fell_seen(input logic now_lvl, input logic was_lvl);
    fell_seen = !now_lvl && was_lvl;
  endfunction : fell_seen

  // Sequencer: walks the repeated start on the two lines
  always_comb begin
    nxt_state  = state_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    brg_load   = 1'b0;
    ev_done    = 1'b0;
    ev_bcol    = 1'b0;
    case (state_ff)
      RSQ_IDLE: begin
        if (restart_enable_bit_ff) begin
          nxt_scl_oe = 1'b1;
          nxt_state  = RSQ_SCL_LOW;
        end
      end
      RSQ_SCL_LOW: begin
        if (!scl_i) begin
          brg_load   = 1'b1;
          nxt_sda_oe = 1'b0;
          nxt_state  = RSQ_SDA_HIGH;
        end
      end
      RSQ_SDA_HIGH: begin
        if (brg_link.expired) begin
          if (sda_i) begin
            nxt_scl_oe = 1'b0;
            nxt_state  = RSQ_SCL_REL;
          end else begin
            ev_bcol = 1'b1;
          end
        end
      end
      RSQ_SCL_REL: begin
        if (rose_seen(scl_i, scl_q_ff) && !sda_i) begin
          ev_bcol = 1'b1;
        end else if (scl_i) begin
          brg_load  = 1'b1;
          nxt_state = RSQ_HOLD_HIGH;
        end
      end
      RSQ_HOLD_HIGH: begin
        if (!scl_i) begin
          ev_bcol = 1'b1;
        end else if (!sda_i) begin
          ev_bcol = 1'b1;
        end else if (brg_link.expired) begin
          nxt_sda_oe = 1'b1;
          brg_load   = 1'b1;
          nxt_state  = RSQ_SDA_LOW;
        end
      end
      RSQ_SDA_LOW: begin
        if (brg_link.expired) begin
          nxt_scl_oe = 1'b1;
          ev_done    = 1'b1;
          nxt_state  = RSQ_IDLE;
        end
      end
      default: begin
        nxt_state = RSQ_IDLE;
      end
    endcase
    // Any collision drops both lines and returns to idle
    if (ev_bcol) begin
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
      nxt_state  = RSQ_IDLE;
    end
  end

  assign brg_link.load   = brg_load;
  assign brg_link.reload = baud_ff;

  // Control registers: restart request, baud reload, control one
  always_comb begin
    nxt_restart_enable_bit    = restart_enable_bit_ff;
    nxt_baud    = baud_ff;
    nxt_ctl_one = ctl_one_ff;
    if (wr_hit(OFS_CTL_ONE)) begin
      // Flag bits clear on a written zero only
      nxt_ctl_one = reg_wdata;
      nxt_ctl_one[BIT_WRITE_COLLIDE_FLAG] = ctl_one_ff[BIT_WRITE_COLLIDE_FLAG] & reg_wdata[BIT_WRITE_COLLIDE_FLAG];
      nxt_ctl_one[BIT_OVF]  = ctl_one_ff[BIT_OVF] & reg_wdata[BIT_OVF];
    end
    if (wr_hit(OFS_BAUD)) begin
      nxt_baud = reg_wdata[BRG_W-1:0];
    end
    // Restart request is taken only while idle and the bus is free
    if (wr_hit(OFS_CTL_TWO) && reg_wdata[BIT_RESTART_ENABLE_BIT]) begin
      if (state_ff == RSQ_IDLE && !restart_enable_bit_ff && !other_event_busy
          && ctl_one_ff[BIT_PEN]) begin
        nxt_restart_enable_bit = 1'b1;
      end else begin
        nxt_ctl_one[BIT_WRITE_COLLIDE_FLAG] = 1'b1;
      end
    end
    // Request stays set through the sequence, hardware clears it at the end
    if (ev_done || ev_bcol) begin
      nxt_restart_enable_bit = 1'b0;
    end
  end

  // Line monitor: start sets the flag, stop clears it
  always_comb begin
    nxt_start = start_ff;
    if (scl_i && scl_q_ff && fell_seen(sda_i, sda_q_ff)) begin
      nxt_start = 1'b1;
    end else if (scl_i && scl_q_ff && rose_seen(sda_i, sda_q_ff)) begin
      nxt_start = 1'b0;
    end
  end

  // Interrupt flags: set wins over a clear in the same cycle
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_en   = irq_en_ff;
    if (wr_hit(OFS_IRQ_CLR)) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[IRQ_W-1:0];
    end
    if (wr_hit(OFS_IRQ_EN)) begin
      nxt_irq_en = reg_wdata[IRQ_W-1:0];
    end
    if (ev_done) begin
      nxt_irq_stat[IRQ_EVENT] = 1'b1;
    end
    if (ev_bcol) begin
      nxt_irq_stat[IRQ_BCOL] = 1'b1;
    end
    nxt_irq = |(irq_stat_ff & irq_en_ff);
  end

  // Read port: data stands in the cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTL_ONE:  nxt_rdata = ctl_one_ff;
        OFS_CTL_TWO:  nxt_rdata[BIT_RESTART_ENABLE_BIT] = restart_enable_bit_ff;
        OFS_BAUD:     nxt_rdata[BRG_W-1:0] = baud_ff;
        OFS_STATUS:   nxt_rdata[BIT_START] = start_ff;
        OFS_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
        OFS_IRQ_EN:   nxt_rdata[IRQ_W-1:0] = irq_en_ff;
        default:      nxt_rdata = RD_UNMAPPED;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff    <= RSQ_IDLE;
      scl_oe_ff   <= 1'b0;
      sda_oe_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      scl_oe_ff   <= nxt_scl_oe;
      sda_oe_ff   <= nxt_sda_oe;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctl_one_ff  <= RST_CTL_ONE;
      restart_enable_bit_ff     <= 1'b0;
      baud_ff     <= RST_BAUD;
    end else begin
      ctl_one_ff  <= nxt_ctl_one;
      restart_enable_bit_ff     <= nxt_restart_enable_bit;
      baud_ff     <= nxt_baud;
    end
  end

  // Line samples and start flag; lines read as idle high after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_ff    <= 1'b0;
      scl_q_ff    <= 1'b1;
      sda_q_ff    <= 1'b1;
    end else begin
      start_ff    <= nxt_start;
      scl_q_ff    <= scl_i;
      sda_q_ff    <= sda_i;
    end
  end

  // Interrupt registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_en_ff   <= '0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff   <= nxt_irq_en;
      irq_ff      <= nxt_irq;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff    <= 8'h00;
    end else begin
      rdata_ff    <= nxt_rdata;
    end
  end

  // Open-drain pins only ever pull low
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_oe_ff;
  assign sda_oe    = sda_oe_ff;
  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;
endmodule : rsq_top

// file: rsq_top_monitor.sv
// Port checker for the repeated start sequencer
`timescale 1ns/10ps
module rsq_top_monitor
  import rsq_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       other_event_busy,
  input wire logic       scl_i,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_oe,
  input wire logic       irq
);
  logic [8:0] q_ff;
  logic       en_ff;
  logic       rs_wr;
  assign rs_wr = reg_wr && reg_addr == OFS_CTL_TWO && reg_wdata[BIT_RESTART_ENABLE_BIT];
  // Quiet time with both lines released, and the enable bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_ff  <= 9'h000;
      en_ff <= 1'b0;
    end else begin
      q_ff <= (scl_oe || sda_oe) ? 9'h000 : q_ff + 9'(q_ff != 9'h1ff);
      if (reg_wr && reg_addr == OFS_CTL_ONE) begin
        en_ff <= reg_wdata[BIT_PEN];
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_drive;
    sda_oe throughout (##[1:600] scl_oe);
  endsequence
  property p_start;
    rs_wr && en_ff && !other_event_busy && q_ff == 9'h1ff |-> ##2 scl_oe && !sda_oe;
  endproperty
  property p_refuse;
    rs_wr && other_event_busy && !scl_oe |=> (!scl_oe)[*2];
  endproperty
  property p_rel;
    $rose(scl_oe) && !sda_oe |-> !sda_oe throughout (##[1:600] !scl_oe);
  endproperty
  property p_data_low;
    $rose(sda_oe) |-> !scl_oe ##0 s_drive;
  endproperty
  property p_keep;
    scl_oe && sda_oe && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> sda_oe;
  endproperty
  property p_irq;
    $rose(irq) |-> scl_oe == sda_oe;
  endproperty
  property p_clk_col;
    !scl_oe && !sda_oe && !scl_i && !$past(scl_oe) && !$past(sda_oe) |=> !sda_oe;
  endproperty
  property p_unmap;
    reg_rd && reg_addr > OFS_IRQ_EN |=> reg_rdata == RD_UNMAPPED;
  endproperty
  a_start: assert property (p_start)
    else $error("restart did not pull clock low");
  a_refuse: assert property (p_refuse)
    else $error("busy restart was taken");
  a_rel: assert property (p_rel)
    else $error("data driven while clock held");
  a_data_low: assert property (p_data_low)
    else $error("data low phase wrong");
  a_keep: assert property (p_keep)
    else $error("data released after finish");
  a_irq: assert property (p_irq)
    else $error("interrupt before sequence end");
  a_clk_col: assert property (p_clk_col)
    else $error("data driven after clock collision");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
endmodule : rsq_top_monitor
bind rsq_top rsq_top_monitor u_mon (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .other_event_busy, .scl_i, .scl_oe, .sda_i, .sda_oe, .irq);

// file: rsq_bus_model.sv
// Bus partner: pull-ups, a stretching slave and a rival master
`timescale 1ns/10ps
module rsq_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  input  wire logic       sda_pull,
  input  wire logic       scl_pull,
  input  wire logic [3:0] stretch,
  output logic            scl,
  output logic            sda
);
  logic [3:0] st_ff = 4'h0;
  logic [3:0] nxt_st;
  // Slave holds the clock low a few cycles after the master lets go
  always_comb begin
    nxt_st = scl_oe ? stretch : st_ff - 4'(st_ff != 4'h0);
  end
  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end
  // Open-drain lines with pull-ups
  assign scl = !(scl_oe || scl_pull || st_ff != 4'h0);
  assign sda = !(sda_oe || sda_pull);
endmodule : rsq_bus_model

// file: rsq_top_test.sv
// Self-checking bench for the repeated start sequencer
`timescale 1ns/10ps
module rsq_top_test;
  import rsq_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       other_event_busy = 1'b0;
  logic       sda_pull = 1'b0;
  logic       scl_pull = 1'b0;
  logic [3:0] stretch = 4'h0;
  logic [7:0] reg_rdata;
  logic       scl_i, sda_i, scl_oe, sda_oe, irq;
  logic [7:0] d;
  int         fails = 0;
  int         n_tests = 0;

  always #5 sys_clk = ~sys_clk;

  rsq_top uut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .other_event_busy, .scl_i, .scl_o(), .scl_oe, .sda_i, .sda_o(), .sda_oe, .irq);
  rsq_bus_model bus (.sys_clk, .scl_oe, .sda_oe, .sda_pull, .scl_pull, .stretch,
    .scl(scl_i), .sda(sda_i));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // Reset values, read-back and an unmapped place
  task automatic t_regs;
    rd(OFS_CTL_ONE);
    chk(d, RST_CTL_ONE);
    rd(OFS_BAUD);
    chk(d, RST_BAUD);
    rd(8'h2c);
    chk(d, RD_UNMAPPED);
    rd(OFS_STATUS);
    chk(d, 8'h00);
    wr(OFS_CTL_ONE, 8'h3f);
    rd(OFS_CTL_ONE);
    chk(d, 8'h3f);
  endtask : t_regs
  // Restart request while another event runs
  task automatic t_refuse;
    @(posedge sys_clk);
    other_event_busy <= 1'b1;
    wr(OFS_CTL_TWO, 8'h02);
    cyc(3);
    chk(8'(scl_oe), 8'h00);
    rd(OFS_CTL_ONE);
    chk(d, 8'hbf);
    @(posedge sys_clk);
    other_event_busy <= 1'b0;
    wr(OFS_CTL_ONE, 8'h3f);
    rd(OFS_CTL_ONE);
    chk(d, 8'h3f);
  endtask : t_refuse
  // One sequence: 0 clean, 1 data low at expiry, 2 clock collision, 3 data low at clock rise
  task automatic t_seq(input int mode, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge sys_clk);
    stretch <= st;
    wr(OFS_CTL_TWO, 8'h02);
    rd(OFS_CTL_TWO);
    chk(d & 8'h02, 8'h02);
    chk(8'(scl_oe), 8'h01);
    @(posedge sys_clk);
    sda_pull <= (mode == 1);
    #1;
    for (int i = 0; i < 300 && scl_oe; i++) cyc(1);
    chk(8'({scl_oe, sda_oe}), 8'h00);
    @(posedge sys_clk);
    sda_pull <= (mode == 3);
    #1;
    for (int i = 0; i < 300 && !sda_oe && mode == 0; i++) begin
      cyc(1);
      n += int'(scl_i && sda_i);
    end
    if (mode == 0) chk(8'(n >= 10), 8'h01);
    if (mode == 2) begin
      for (int i = 0; i < 300 && !scl_i; i++) cyc(1);
      repeat (2) @(posedge sys_clk);
      scl_pull <= 1'b1;
      repeat (2) @(posedge sys_clk);
      scl_pull <= 1'b0;
      #1;
    end
    for (int i = 0; i < 300 && !irq; i++) cyc(1);
    chk(8'(irq), 8'h01);
    @(posedge sys_clk);
    sda_pull <= 1'b0;
    rd(OFS_IRQ_STAT);
    chk(d, (mode == 0) ? 8'h01 : 8'h02);
    rd(OFS_CTL_TWO);
    chk(d, 8'h00);
    chk(8'({scl_oe, sda_oe}), (mode == 0) ? 8'h03 : 8'h00);
    rd(OFS_STATUS);
    if (mode == 0) chk(d & 8'h08, 8'h08);
    wr(OFS_IRQ_CLR, 8'h03);
    cyc(1);
    chk(8'(irq), 8'h00);
  endtask : t_seq

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_refuse;
    wr(OFS_IRQ_EN, 8'h03);
    wr(OFS_BAUD, 8'h09);
    cyc(520);
    t_seq(0, 4'h0);
    t_seq(0, 4'h3);
    t_seq(1, 4'h0);
    t_seq(2, 4'h0);
    t_seq(3, 4'h3);
    finish_test;
  end
  // Watchdog against a hung sequence
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule : rsq_top_test
